// ### src/srl_pkg.sv
`default_nettype none
package srl_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int WORD_W = 10;
    localparam logic [9:0] LOSS_WORD = 10'h3ff;

    // ------------------------------------------------------------
    // Rates and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int LOCK_US = 500;
    localparam int LOCK_CYC = LOCK_US * CLK_MHZ;
    localparam int SYNC_BITS_MAX = 2500;
    localparam int SYNC_BITS_TYP = 200;
    localparam int LOS_AMP_MIN = 8;

    // ------------------------------------------------------------
    // Register map (APB byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CL = 8'h10;
    localparam logic [7:0] ADDR_TXCAP  = 8'h14;
    localparam logic [7:0] ADDR_RXWORD = 8'h18;
    localparam logic [7:0] ADDR_AMP    = 8'h1c;

    // Control bits
    localparam int CTRL_TX_RATE = 0;
    localparam int CTRL_RX_RATE = 1;
    localparam int CTRL_ALIGN   = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Interrupt event bits
    localparam int IRQ_LOSS_SET = 0;
    localparam int IRQ_LOSS_CLR = 1;
    localparam int IRQ_LOCK     = 2;
    localparam int IRQ_W        = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_FREQ = 2'b01,
        LK_SYNC = 2'b10,
        LK_DONE = 2'b11
    } srl_lock_e;

    typedef struct packed {
        logic       loss;
        logic [9:0] word;
    } srl_rx_s;

endpackage
`default_nettype wire

// ### src/srl_core.sv
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Small input amplitude raises loss flag and forces receive word all ones.
// - Valid amplitude clears loss flag and passes deserialized stream through.
// - Rate select and alignment mode choose 53.125 or 106.25 MHz clocks.
// - Transmit speed 0 captures word on falling transmit clock edge only.
// - Transmit latency is about 8.5 bit times plus fixed delay.
// - Serializer sends bit 0 first, then higher bits in order.
// - Receive latency is about 13.5 ns plus 2.5 bit times.
// - Frequency lock is reached within 500 microseconds after power-up.
// - Bit sync after phase jump within 2500 bit times, typically 200.
// - Half-rate mode: second receive clock trails first by half a clock period (two words).
// - Transmit speed 1 captures one word on each transmit clock edge.
// - Receive path takes serial input; loss gate acts on that stream.
module srl_core #(
    parameter int LOCK_CYCLES = srl_pkg::LOCK_CYC
) (
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    // Transmit side
    input  wire logic        xmit_byte_clock,
    input  wire logic [9:0]  tx_word,
    output logic             serial_out,
    // Receive side
    input  wire logic        serial_in,
    input  wire logic [7:0]  serial_amp,
    input  wire logic        reference_clock_in,
    output logic      [9:0]  rx_word,
    output logic             signal_loss_flag,
    output logic             recv_clock_first,
    output logic             recv_clock_second
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0]  tbc_q;
    logic [9:0]  txw_m_q, txw_q;
    logic [1:0]  si_q, ref_q;
    logic [7:0]  amp_m_q, amp_q;

    // Two-flop capture; third tbc stage only for edge finding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbc_q   <= 3'h0;
            txw_m_q <= 10'h000;
            txw_q   <= 10'h000;
            si_q    <= 2'h0;
            ref_q   <= 2'h0;
            amp_m_q <= 8'h00;
            amp_q   <= 8'h00;
        end else begin
            tbc_q   <= {tbc_q[1:0], xmit_byte_clock};
            txw_m_q <= tx_word;
            txw_q   <= txw_m_q;
            si_q    <= {si_q[0], serial_in};
            ref_q   <= {ref_q[0], reference_clock_in};
            amp_m_q <= serial_amp;
            amp_q   <= amp_m_q;
        end
    end

    // ------------------------------------------------------------
    // Control register decode
    // ------------------------------------------------------------
    logic [2:0]  ctrl_q;
    logic [srl_pkg::IRQ_W-1:0] ist_q, ien_q;
    logic        wr_en, rd_en;
    logic        tx_rate, rx_rate, align_mode;

    // Bus strobes and control fields
    assign wr_en      = psel & penable & pwrite;
    assign rd_en      = psel & penable & ~pwrite;
    assign pready     = 1'b1;
    assign tx_rate    = ctrl_q[srl_pkg::CTRL_TX_RATE];
    assign rx_rate    = ctrl_q[srl_pkg::CTRL_RX_RATE];
    assign align_mode = ctrl_q[srl_pkg::CTRL_ALIGN];

    // ------------------------------------------------------------
    // Transmit capture and serializer
    // ------------------------------------------------------------
    logic        tbc_rise, tbc_fall, tx_take;
    logic [9:0]  tx_cap_q, tx_sh_q;
    logic [3:0]  tx_cnt_q;

    // Edge finder on the synchronised byte clock
    assign tbc_rise = tbc_q[1] & ~tbc_q[2];
    assign tbc_fall = ~tbc_q[1] & tbc_q[2];
    // Rate 0 takes falling edges only, rate 1 both edges
    assign tx_take  = tbc_fall | (tx_rate & tbc_rise);

    // Word latched, then shifted out LSB first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cap_q <= 10'h000;
            tx_sh_q  <= 10'h000;
            tx_cnt_q <= 4'h0;
        end else if (tx_take) begin
            tx_cap_q <= txw_q;
            tx_sh_q  <= txw_q;
            tx_cnt_q <= 4'h0;
        end else if (tx_cnt_q != 4'h9) begin
            tx_sh_q  <= {1'b0, tx_sh_q[9:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
        end
    end

    assign serial_out = tx_sh_q[0];

    // ------------------------------------------------------------
    // Receive deserializer with loss gate
    // ------------------------------------------------------------
    logic [9:0]  rx_sh_q;
    logic [3:0]  rx_cnt_q;
    logic        word_end, amp_low;
    srl_pkg::srl_rx_s rx_q;

    // Word boundary and amplitude threshold
    assign word_end = (rx_cnt_q == 4'h9);
    assign amp_low  = (amp_q < 8'(srl_pkg::LOS_AMP_MIN));

    // Serial input shifts in, first bit lands in bit 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sh_q  <= 10'h000;
            rx_cnt_q <= 4'h0;
        end else begin
            rx_sh_q  <= {si_q[1], rx_sh_q[9:1]};
            rx_cnt_q <= word_end ? 4'h0 : rx_cnt_q + 4'h1;
        end
    end

    // Word and flag only update on word boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_q <= '{loss: 1'b1, word: srl_pkg::LOSS_WORD};
        end else if (word_end) begin
            rx_q.loss <= amp_low;
            rx_q.word <= amp_low ? srl_pkg::LOSS_WORD
                                 : {si_q[1], rx_sh_q[9:1]};
        end
    end

    assign rx_word          = rx_q.word;
    assign signal_loss_flag = rx_q.loss;

    // ------------------------------------------------------------
    // Receive byte clocks
    // ------------------------------------------------------------
    logic [1:0]  rbc_q;
    logic        div_q;

    // Half-rate: toggle every second word, second clock half a period late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 1'b0;
            rbc_q <= 2'h0;
        end else if (word_end) begin
            div_q <= ~div_q;
            if (!rx_rate && !align_mode) begin
                if (div_q) begin
                    rbc_q <= {rbc_q[0], ~rbc_q[0]};
                end
            end else begin
                rbc_q <= {~rbc_q[1], ~rbc_q[1]};
            end
        end
    end

    assign recv_clock_first  = rbc_q[0];
    assign recv_clock_second = rbc_q[1];

    // ------------------------------------------------------------
    // Lock sequencing
    // ------------------------------------------------------------
    srl_pkg::srl_lock_e lk_q, lk_d;
    logic [31:0] lk_cnt_q;
    logic        ref_seen_q, lock_ev;

    // Reference clock activity starts the frequency lock count
    always_comb begin
        lk_d = lk_q;
        case (lk_q)
            srl_pkg::LK_IDLE: if (ref_seen_q) lk_d = srl_pkg::LK_FREQ;
            srl_pkg::LK_FREQ: if (lk_cnt_q >= 32'(LOCK_CYCLES - 1)) lk_d = srl_pkg::LK_SYNC;
            srl_pkg::LK_SYNC: if (lk_cnt_q >= 32'(srl_pkg::SYNC_BITS_TYP - 1) || amp_low)
                                  lk_d = amp_low ? srl_pkg::LK_SYNC : srl_pkg::LK_DONE;
            srl_pkg::LK_DONE: if (amp_low) lk_d = srl_pkg::LK_SYNC;
            default:          lk_d = srl_pkg::LK_IDLE;
        endcase
    end

    assign lock_ev = (lk_q == srl_pkg::LK_SYNC) && (lk_d == srl_pkg::LK_DONE);

    // State and count of the lock sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk_q       <= srl_pkg::LK_IDLE;
            lk_cnt_q   <= 32'h0;
            ref_seen_q <= 1'b0;
        end else begin
            lk_q       <= lk_d;
            // Signal loss only restarts bit sync; frequency lock runs off the reference
            lk_cnt_q   <= (lk_d != lk_q || (amp_low && lk_q == srl_pkg::LK_SYNC)) ? 32'h0
                                                                               : lk_cnt_q + 32'h1;
            ref_seen_q <= ref_seen_q | (ref_q[1] ^ ref_q[0]);
        end
    end

    // ------------------------------------------------------------
    // Registers and interrupts
    // ------------------------------------------------------------
    logic [srl_pkg::IRQ_W-1:0] ev, clr;
    logic        loss_prev_q;

    // Status events: lock reached, loss cleared, loss raised
    assign ev  = {lock_ev, loss_prev_q & ~rx_q.loss, ~loss_prev_q & rx_q.loss};
    assign clr = (wr_en && paddr == srl_pkg::ADDR_IRQ_CL) ? pwdata[srl_pkg::IRQ_W-1:0] : '0;
    assign irq = |(ist_q & ien_q);

    // Sticky status, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q      <= srl_pkg::CTRL_RESET;
            ien_q       <= '0;
            ist_q       <= '0;
            loss_prev_q <= 1'b1;
        end else begin
            loss_prev_q <= rx_q.loss;
            ist_q       <= (ist_q & ~clr) | ev;
            if (wr_en && paddr == srl_pkg::ADDR_CTRL) ctrl_q <= pwdata[2:0];
            if (wr_en && paddr == srl_pkg::ADDR_IRQ_EN) ien_q <= pwdata[srl_pkg::IRQ_W-1:0];
        end
    end

    // Read mux
    always_comb begin
        prdata  = 32'h0;
        pslverr = 1'b0;
        case (paddr)
            srl_pkg::ADDR_CTRL:   prdata = {29'h0, ctrl_q};
            srl_pkg::ADDR_STATUS: prdata = {28'h0, lk_q, rx_q.loss, ref_seen_q};
            srl_pkg::ADDR_IRQ_ST: prdata = {29'h0, ist_q};
            srl_pkg::ADDR_IRQ_EN: prdata = {29'h0, ien_q};
            srl_pkg::ADDR_IRQ_CL: prdata = 32'h0;
            srl_pkg::ADDR_TXCAP:  prdata = {22'h0, tx_cap_q};
            srl_pkg::ADDR_RXWORD: prdata = {22'h0, rx_q.word};
            srl_pkg::ADDR_AMP:    prdata = {24'h0, amp_q};
            default:              pslverr = psel & penable;
        endcase
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    loss_word_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_q.loss |-> rx_q.word == srl_pkg::LOSS_WORD) else $error("loss word not ones");
    loss_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        word_end && amp_low |=> rx_q.loss) else $error("loss flag not raised");
    loss_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        word_end && !amp_low |=> !rx_q.loss) else $error("loss flag not cleared");
    word_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        !word_end |=> $stable(rx_q)) else $error("rx word changed mid word");
    fall_take_a: assert property (@(posedge pclk) disable iff (!presetn)
        !tx_rate && tbc_rise |=> tx_cnt_q != 4'h0)
        else $error("rising edge captured at rate 0");
    lsb_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_take |=> serial_out == $past(txw_q[0])) else $error("bit 0 not first");
    both_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_rate && tbc_rise |=> tx_cap_q == $past(txw_q)) else $error("rise not captured");
    lock_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        lk_q == srl_pkg::LK_FREQ |-> lk_cnt_q < 32'(LOCK_CYCLES)) else $error("lock late");
    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(ist_q & ien_q)) else $error("irq mismatch");
    sticky_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev != '0 |=> (ist_q & $past(ev)) == $past(ev)) else $error("status event lost");
    clk_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_rate || align_mode) && word_end |=> recv_clock_first == recv_clock_second)
        else $error("receive clocks not paired");
    interleave_a: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(rx_rate) && !$past(align_mode) && $rose(recv_clock_second) |-> !recv_clock_first)
        else $error("receive clocks not interleaved");

    loss_cov_c:  cover property (@(posedge pclk) disable iff (!presetn) $rose(rx_q.loss));
    clear_cov_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(rx_q.loss));
    lock_cov_c:  cover property (@(posedge pclk) disable iff (!presetn) lock_ev);
    ddr_cov_c:   cover property (@(posedge pclk) disable iff (!presetn) tx_rate && tbc_rise);
    half_cov_c:  cover property (@(posedge pclk) disable iff (!presetn)
        $rose(recv_clock_second) && !recv_clock_first);

endmodule
`default_nettype wire

// ### dv/srl_proto_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Parallel-side protocol device model
// ------------------------------------------------------------
module srl_proto_model (
    // Transmit side
    output logic             xmit_byte_clock,
    output logic      [9:0]  tx_word,
    // Receive side
    input  wire logic        recv_clock_first,
    input  wire logic        signal_loss_flag,
    input  wire logic [9:0]  rx_word,
    output logic      [9:0]  good_word
);
    // Byte clock rests low between frames
    initial begin
        xmit_byte_clock = 1'b0;
        tx_word = 10'h000;
        good_word = 10'h000;
    end
    // One word per 80 ns frame, stable around the falling edge only
    task automatic send_sdr(input logic [9:0] w);
        #3 tx_word = ~w;
        xmit_byte_clock = 1'b1;
        #8 tx_word = w;
        #32 xmit_byte_clock = 1'b0;
        #17 tx_word = ~w;           // Released after hold
        #20;
    endtask
    // Word and clock switch together on both edges, 83 ns frame
    task automatic send_ddr(input logic [9:0] a, input logic [9:0] b);
        #3 tx_word = a;
        xmit_byte_clock = 1'b1;
        #40 tx_word = b;
        xmit_byte_clock = 1'b0;
        #40;
    endtask
    // Words received under signal loss are dropped; sampled once settled
    always @(posedge recv_clock_first) begin
        #1;
        if (signal_loss_flag === 1'b0) good_word <= rx_word;
    end
endmodule
`default_nettype wire

// ### dv/serdes_rate_los_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Testbench
// ------------------------------------------------------------
module serdes_rate_los_control_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr, serial_amp;
    logic [31:0] pwdata, prdata;
    logic        xmit_byte_clock, serial_out, serial_in, reference_clock_in;
    logic        signal_loss_flag, recv_clock_first, recv_clock_second;
    logic [9:0]  tx_word, rx_word, good_word;
    int          err_count, samples_checked;

    srl_core #(.LOCK_CYCLES(50)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .xmit_byte_clock, .tx_word,
        .serial_out, .serial_in, .serial_amp, .reference_clock_in, .rx_word,
        .signal_loss_flag, .recv_clock_first, .recv_clock_second);
    srl_proto_model u_proto (.xmit_byte_clock, .tx_word, .recv_clock_first,
        .signal_loss_flag, .rx_word, .good_word);

    // Clocks
    always #4 pclk = ~pclk;
    always @(posedge pclk) reference_clock_in <= ~reference_clock_in;

    // Verdict and end of run
    task automatic wrap_up();
        $display("errors=%0d checks=%0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // APB transfer: hold the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, x);
    endtask
    // Cycles until the chosen receive clock rises
    task automatic wait_rise(input int w, output int n);
        logic prev, cur;
        n = 0;
        cur = w ? recv_clock_second : recv_clock_first;
        do begin
            prev = cur;
            @(posedge pclk);
            cur = w ? recv_clock_second : recv_clock_first;
            n++;
        end while (!(prev === 1'b0 && cur === 1'b1) && n < 200);
    endtask
    task automatic wait_loss(input logic v);
        int n;
        n = 0;
        while (signal_loss_flag !== v && n < 40) begin @(posedge pclk); n++; end
    endtask

    // Control register reset value, read-back and an unmapped address
    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rd(srl_pkg::ADDR_CTRL, 32'h7, 32'(srl_pkg::CTRL_RESET));
        wr(srl_pkg::ADDR_CTRL, 32'h6);
        rd(srl_pkg::ADDR_CTRL, 32'h7, 32'h6);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk(r, 32'h0);
        chk(32'(e), 32'h1);
    endtask
    // Lock reached within the scaled bound
    task automatic t_lock();
        logic [31:0] r;
        logic        e;
        int          n;
        n = 0;
        do begin
            repeat (20) @(posedge pclk);
            apb(1'b0, srl_pkg::ADDR_STATUS, 32'h0, r, e);
            n++;
        end while (r[3:2] !== srl_pkg::LK_DONE && n < 200);
        chk(32'(r[3:2]), 32'(srl_pkg::LK_DONE));
        chk(32'(n <= 115), 32'h1);
        chk(32'(r[0]), 32'h1);
    endtask
    // Loss of signal, forced word, interrupt raise, mask and clear
    task automatic t_loss();
        wr(srl_pkg::ADDR_IRQ_EN, 32'h1);
        wr(srl_pkg::ADDR_IRQ_CL, 32'h7);
        serial_in <= 1'b1;
        serial_amp <= 8'h08;
        repeat (40) @(posedge pclk);
        chk(32'(signal_loss_flag), 32'h0);
        rd(srl_pkg::ADDR_RXWORD, 32'h3ff, 32'h3ff);
        serial_in <= 1'b0;
        repeat (40) @(posedge pclk);
        chk(32'(rx_word), 32'h0);
        serial_amp <= 8'h07;
        wait_loss(1'b1);
        chk(32'(rx_word), 32'(srl_pkg::LOSS_WORD));
        repeat (4) @(posedge pclk);
        chk(32'(irq), 32'h1);
        chk(32'(good_word), 32'h0);
        rd(srl_pkg::ADDR_IRQ_ST, 32'h3, 32'h1);
        wr(srl_pkg::ADDR_IRQ_CL, 32'h1);
        @(posedge pclk);
        chk(32'(irq), 32'h0);
        serial_amp <= 8'h20;
        wait_loss(1'b0);
        chk(32'(rx_word), 32'h0);
        rd(srl_pkg::ADDR_IRQ_ST, 32'h3, 32'h2);
        chk(32'(irq), 32'h0);
        wr(srl_pkg::ADDR_IRQ_EN, 32'h2);
        @(posedge pclk);
        chk(32'(irq), 32'h1);
        wr(srl_pkg::ADDR_IRQ_CL, 32'h2);
        @(posedge pclk);
        chk(32'(irq), 32'h0);
    endtask
    // Falling-edge capture, bit order and latency window
    task automatic t_tx0();
        logic [31:0] b;
        logic        f;
        f = 1'b0;
        wr(srl_pkg::ADDR_CTRL, 32'h0);
        fork
            u_proto.send_sdr(10'h2d1);
            for (int i = 0; i < 32; i++) begin @(posedge pclk); b[i] = serial_out; end
        join
        for (int o = 6; o <= 20; o++) if (b[o+:10] === 10'h2d1) f = 1'b1;
        chk(32'(f), 32'h1);
        rd(srl_pkg::ADDR_TXCAP, 32'h3ff, 32'h2d1);
    endtask
    // One word on each edge at the high transmit rate
    task automatic t_tx1();
        wr(srl_pkg::ADDR_CTRL, 32'h1);
        fork
            u_proto.send_ddr(10'h155, 10'h0aa);
            begin
                repeat (2) @(posedge pclk);
                rd(srl_pkg::ADDR_TXCAP, 32'h3ff, 32'h155);
            end
        join
        rd(srl_pkg::ADDR_TXCAP, 32'h3ff, 32'h0aa);
    endtask
    // Receive clock rates over all four settings, and half-rate offset
    task automatic t_clk();
        int p[4];
        int n, d;
        for (int k = 0; k < 4; k++) begin
            wr(srl_pkg::ADDR_CTRL, 32'(k * 2 + 1));
            wait_rise(0, n);
            wait_rise(0, n);
            wait_rise(0, p[k]);
            if (k == 0) wait_rise(1, d);
        end
        chk(32'(d), 32'(p[0] / 2));
        chk(32'(p[0]), 32'(2 * p[1]));
        chk(32'(p[2]), 32'(p[1]));
        chk(32'(p[3]), 32'(p[1]));
    endtask

    // Main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        serial_in = 1'b0;
        serial_amp = 8'h20;
        reference_clock_in = 1'b0;
        err_count = 0;
        samples_checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_lock();
        t_loss();
        t_tx0();
        t_tx1();
        t_clk();
        wrap_up();
    end
    // Watchdog
    initial begin
        #400000;
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
